// ### hw/stlm_pkg.sv
// Package of the software travel limit monitor: widths, field positions,
// reset values and enable settings.
// Assumes one drive clock and signed 64-bit position values.
package stlm_pkg;

  // Widths of the held values
  localparam int POS_W    = 64;
  localparam int EN_W     = 8;
  localparam int STATUS_W = 8;

  // Field positions in the enable setting and the status word
  localparam int LIMIT0_BIT = 0;
  localparam int LIMIT1_BIT = 1;

  // Enable setting values
  localparam logic [1:0] EN_NONE = 2'h0;
  localparam logic [1:0] EN_ONLY0 = 2'h1;
  localparam logic [1:0] EN_ONLY1 = 2'h2;
  localparam logic [1:0] EN_BOTH = 2'h3;

  // Values after reset
  localparam logic [EN_W-1:0]     ENABLE_RESET   = 8'h00;
  localparam logic [POS_W-1:0]    COMPARE0_RESET = 64'h0000_0000_0000_0000;
  localparam logic [POS_W-1:0]    COMPARE1_RESET = 64'h0000_0000_0010_0000;
  localparam logic [STATUS_W-1:0] STATUS_RESET   = 8'h00;
  localparam logic                TORQUE_RESET   = 1'b0;

endpackage

// ### hw/stlm_cmp_if.sv
// Interface between the monitor top and its bound comparator.
// Assumes both ends sit on the same drive clock.
`timescale 1ns/1ps

interface stlm_cmp_if;
  logic signed [stlm_pkg::POS_W-1:0] compare0;
  logic signed [stlm_pkg::POS_W-1:0] compare1;
  logic signed [stlm_pkg::POS_W-1:0] actualPosition;
  logic [1:0]                        enableBits;
  logic                              axisHomed;
  logic [1:0]                        activeBits;
  logic                              lowerHit;
  logic                              upperHit;

  // Owner of the settings and the position
  modport top (
    output compare0, compare1, actualPosition, enableBits, axisHomed,
    input  activeBits, lowerHit, upperHit
  );

  // Bound comparator
  modport cmp (
    input  compare0, compare1, actualPosition, enableBits, axisHomed,
    output activeBits, lowerHit, upperHit
  );
endinterface

// ### hw/stlm_bound_cmp.sv
// Bound comparator: orders the two compare values into lower and upper
// bounds and flags which compare value the actual position has crossed.
// Assumes inputs synchronous to clk_sys; results appear one cycle later.
`timescale 1ns/1ps

module stlm_bound_cmp (
  input wire logic clk_sys,
  input wire logic resetn,
  stlm_cmp_if.cmp  cmpBus
);

  // Per-bit arming and homing gate
  wire arm0 = cmpBus.axisHomed & cmpBus.enableBits[stlm_pkg::LIMIT0_BIT];
  wire arm1 = cmpBus.axisHomed & cmpBus.enableBits[stlm_pkg::LIMIT1_BIT];

  // Compare 0 becomes the upper bound only with both armed and larger
  wire bothOn   = (cmpBus.enableBits == stlm_pkg::EN_BOTH);
  wire swapped  = bothOn & (cmpBus.compare0 > cmpBus.compare1);

  // Crossing tests on each compare value
  wire below0   = cmpBus.actualPosition < cmpBus.compare0;
  wire above0   = cmpBus.actualPosition > cmpBus.compare0;
  wire below1   = cmpBus.actualPosition < cmpBus.compare1;
  wire above1   = cmpBus.actualPosition > cmpBus.compare1;

  // Limit 0 is lower unless swapped, limit 1 the opposite
  wire hit0 = arm0 & (swapped ? above0 : below0);
  wire hit1 = arm1 & (swapped ? below1 : above1);

  wire [1:0] next_activeBits = {hit1, hit0};
  wire next_lowerHit = swapped ? hit1 : hit0;
  wire next_upperHit = swapped ? hit0 : hit1;

  // Register the comparison result
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmpBus.activeBits <= 2'h0;
      cmpBus.lowerHit   <= 1'b0;
      cmpBus.upperHit   <= 1'b0;
    end else begin
      cmpBus.activeBits <= next_activeBits;
      cmpBus.lowerHit   <= next_lowerHit;
      cmpBus.upperHit   <= next_upperHit;
    end
  end

endmodule

// ### hw/stlm_monitor.sv
// Software travel limit monitor for one servo axis: holds the limit
// settings, watches the actual position and reports active limits.
// Assumes the position loop and homing logic share clk_sys.
`timescale 1ns/1ps

module stlm_monitor (
  input  wire logic                                clk_sys,
  input  wire logic                                resetn,
  // Host setting writes
  input  wire logic                                enableWrite,
  input  wire logic [stlm_pkg::EN_W-1:0]           enableData,
  input  wire logic                                compare0Write,
  input  wire logic                                compare1Write,
  input  wire logic signed [stlm_pkg::POS_W-1:0]   compareData,
  // Position loop, homing and safety inputs
  input  wire logic signed [stlm_pkg::POS_W-1:0]   actualPosition,
  input  wire logic                                axisHomed,
  input  wire logic                                hwLimitLower,
  input  wire logic                                hwLimitUpper,
  input  wire logic                                safeTorqueCutoff,
  // Register read back
  output logic [stlm_pkg::EN_W-1:0]                travel_limit_enable,
  output logic signed [stlm_pkg::POS_W-1:0]        travel_limit_compare_0,
  output logic signed [stlm_pkg::POS_W-1:0]        travel_limit_compare_1,
  output logic [stlm_pkg::STATUS_W-1:0]            travel_limit_status,
  output logic                                     torque_off_status,
  // Motion inhibits toward the position loop
  output logic                                     inhibitLower,
  output logic                                     inhibitUpper
);

  stlm_cmp_if cmpBus ();

  // Only settings 0 to 3 have meaning; higher bits are dropped
  wire [stlm_pkg::EN_W-1:0] enableClipped = {6'h00, enableData[1:0]};

  // Feed the comparator
  assign cmpBus.compare0       = travel_limit_compare_0;
  assign cmpBus.compare1       = travel_limit_compare_1;
  assign cmpBus.actualPosition = actualPosition;
  assign cmpBus.enableBits     = travel_limit_enable[1:0];
  assign cmpBus.axisHomed      = axisHomed;

  stlm_bound_cmp u_stlm_bound_cmp (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .cmpBus  (cmpBus)
  );

  // Next status: two limit bits, the rest fixed at zero
  wire [stlm_pkg::STATUS_W-1:0] next_status = {6'h00, cmpBus.activeBits};

  // Torque permitted unless the safety cutoff reports a fault
  wire next_torque = ~safeTorqueCutoff;

  // Settings held by the block, default values after reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      travel_limit_enable    <= stlm_pkg::ENABLE_RESET;
      travel_limit_compare_0 <= stlm_pkg::COMPARE0_RESET;
      travel_limit_compare_1 <= stlm_pkg::COMPARE1_RESET;
    end else begin
      if (enableWrite) begin
        travel_limit_enable <= enableClipped;
      end
      if (compare0Write) begin
        travel_limit_compare_0 <= compareData;
      end
      if (compare1Write) begin
        travel_limit_compare_1 <= compareData;
      end
    end
  end

  // Status and torque-off readings
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      travel_limit_status <= stlm_pkg::STATUS_RESET;
      torque_off_status   <= stlm_pkg::TORQUE_RESET;
    end else begin
      travel_limit_status <= next_status;
      torque_off_status   <= next_torque;
    end
  end

  // Hardware limits act on their own, software limits add to them
  assign inhibitLower = hwLimitLower | cmpBus.lowerHit;
  assign inhibitUpper = hwLimitUpper | cmpBus.upperHit;

  // Checks on the settings, the gating and the ordering of bounds

  // Setting 0 keeps the whole status word clear
  a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    $past(cmpBus.enableBits) == stlm_pkg::EN_NONE |=> travel_limit_status == 8'h00)
    else $error("Status set while both limits disabled");

  // Setting 0 keeps both software hits low as well
  a_disabled_no_hit: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmpBus.enableBits == stlm_pkg::EN_NONE |=> !cmpBus.lowerHit && !cmpBus.upperHit)
    else $error("Software hit while both limits disabled");

  // An unhomed axis shows no active limit two cycles on
  a_unhomed_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
    !axisHomed ##1 !$past(axisHomed) |=> travel_limit_status[1:0] == 2'h0)
    else $error("Status set while axis not homed");

  // An unhomed axis raises no software hit one cycle on
  a_unhomed_no_hit: assert property (@(posedge clk_sys) disable iff (!resetn)
    !axisHomed |=> !cmpBus.lowerHit && !cmpBus.upperHit)
    else $error("Software hit while axis not homed");

  // Any active comparator bit needs a homed axis one cycle before
  a_hit_needs_homed: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmpBus.activeBits != 2'h0 |-> $past(axisHomed))
    else $error("Active limit without homing");

  // Unused status bits stay zero
  a_high_bits_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    travel_limit_status[7:2] == 6'h00)
    else $error("Unused status bits not zero");

  // Only the low two bits of the enable setting are kept
  a_enable_high_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    travel_limit_enable[7:2] == 6'h00)
    else $error("Enable setting holds high bits");

  // An enable write lands one cycle on, clipped to two bits
  a_enable_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    enableWrite |=> travel_limit_enable == {6'h00, $past(enableData[1:0])})
    else $error("Enable write lost");

  // Without a write the enable setting holds
  a_enable_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !enableWrite |=> $stable(travel_limit_enable))
    else $error("Enable setting changed without a write");

  // A disarmed limit 0 shows no active bit two cycles on
  a_bit0_armed: assert property (@(posedge clk_sys) disable iff (!resetn)
    !travel_limit_enable[0] |-> ##2 !travel_limit_status[0])
    else $error("Limit 0 active while disarmed");

  // A disarmed limit 1 shows no active bit two cycles on
  a_bit1_armed: assert property (@(posedge clk_sys) disable iff (!resetn)
    !travel_limit_enable[1] |-> ##2 !travel_limit_status[1])
    else $error("Limit 1 active while disarmed");

  // Each comparator bit needs its arming bit one cycle before
  a_hit_needs_arm: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cmpBus.activeBits & ~$past(cmpBus.enableBits)) == 2'h0)
    else $error("Comparator bit set without its arming bit");

  // One limit armed: limit 0 flags a position below it
  a_single_lower: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_ONLY0
      && actualPosition < travel_limit_compare_0
    |=> ##1 travel_limit_status[0])
    else $error("Limit 0 below lower bound not flagged");

  // One limit armed: limit 1 flags a position above it
  a_single_upper: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_ONLY1
      && actualPosition > travel_limit_compare_1
    |=> ##1 travel_limit_status[1])
    else $error("Limit 1 above upper bound not flagged");

  // One limit armed: limit 0 never acts as an upper bound
  a_only0_no_upper: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_ONLY0
      && actualPosition > travel_limit_compare_0
    |=> ##1 travel_limit_status == 8'h00)
    else $error("Limit 0 flagged above its lower bound");

  // One limit armed: limit 1 never acts as a lower bound
  a_only1_no_lower: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_ONLY1
      && actualPosition < travel_limit_compare_1
    |=> ##1 travel_limit_status == 8'h00)
    else $error("Limit 1 flagged below its upper bound");

  // Lower and upper hits never stand together
  a_hits_exclusive: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(cmpBus.lowerHit && cmpBus.upperHit))
    else $error("Lower and upper hit together");

  // Both armed in order: below compare 0 is a lower hit on limit 0
  a_both_lower: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_BOTH
      && travel_limit_compare_0 < travel_limit_compare_1
      && actualPosition < travel_limit_compare_0
    |=> cmpBus.lowerHit ##1 travel_limit_status == 8'h01)
    else $error("Lower hit on compare 0 not flagged");

  // Both armed in order: above compare 1 is an upper hit on limit 1
  a_both_upper: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_BOTH
      && travel_limit_compare_0 < travel_limit_compare_1
      && actualPosition > travel_limit_compare_1
    |=> cmpBus.upperHit ##1 travel_limit_status == 8'h02)
    else $error("Upper hit on compare 1 not flagged");

  // Both armed, compare 0 larger: above it is an upper hit on limit 0
  a_both_swapped: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_BOTH
      && travel_limit_compare_0 > travel_limit_compare_1
      && actualPosition > travel_limit_compare_0
    |=> cmpBus.upperHit ##1 travel_limit_status == 8'h01)
    else $error("Larger compare 0 not used as upper bound");

  // Both armed, compare 0 larger: below compare 1 is a lower hit on limit 1
  a_swapped_lower: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_BOTH
      && travel_limit_compare_0 > travel_limit_compare_1
      && actualPosition < travel_limit_compare_1
    |=> cmpBus.lowerHit ##1 travel_limit_status == 8'h02)
    else $error("Smaller compare 1 not used as lower bound");

  // A position on both compare values flags nothing
  a_inside_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    actualPosition == travel_limit_compare_0 && actualPosition == travel_limit_compare_1
    |=> ##1 travel_limit_status == 8'h00)
    else $error("Status set on a bound itself");

  // A position equal to compare 0 is not beyond it
  a_equal_lower: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_ONLY0
      && actualPosition == travel_limit_compare_0
    |=> ##1 !travel_limit_status[0])
    else $error("Limit 0 flagged on its bound");

  // A position equal to compare 1 is not beyond it
  a_equal_upper: assert property (@(posedge clk_sys) disable iff (!resetn)
    axisHomed && travel_limit_enable[1:0] == stlm_pkg::EN_ONLY1
      && actualPosition == travel_limit_compare_1
    |=> ##1 !travel_limit_status[1])
    else $error("Limit 1 flagged on its bound");

  // Status bits copy the comparator result one cycle late
  a_status_follows: assert property (@(posedge clk_sys) disable iff (!resetn)
    travel_limit_status[1:0] == $past(cmpBus.activeBits))
    else $error("Status does not follow the comparison");

  // Both status bits never stand together
  a_status_not_both: assert property (@(posedge clk_sys) disable iff (!resetn)
    travel_limit_status[1:0] != 2'h3)
    else $error("Both limit bits active");

  // A software hit always shows in the comparator bits
  a_hits_have_bits: assert property (@(posedge clk_sys) disable iff (!resetn)
    cmpBus.lowerHit || cmpBus.upperHit |-> cmpBus.activeBits != 2'h0)
    else $error("Software hit without an active bit");

  // Hardware limits always reach the inhibits
  a_hw_passes: assert property (@(posedge clk_sys) disable iff (!resetn)
    (hwLimitLower |-> inhibitLower) and (hwLimitUpper |-> inhibitUpper))
    else $error("Hardware limit masked");

  // Software hits always reach the inhibits
  a_sw_passes: assert property (@(posedge clk_sys) disable iff (!resetn)
    (cmpBus.lowerHit |-> inhibitLower) and (cmpBus.upperHit |-> inhibitUpper))
    else $error("Software hit masked");

  // With no hardware input the inhibits show the software hits alone
  a_sw_only: assert property (@(posedge clk_sys) disable iff (!resetn)
    !hwLimitLower && !hwLimitUpper
    |-> inhibitLower == cmpBus.lowerHit && inhibitUpper == cmpBus.upperHit)
    else $error("Inhibit without a cause");

  // A cutoff fault gives torque-off status 0 one cycle on
  a_torque_state: assert property (@(posedge clk_sys) disable iff (!resetn)
    safeTorqueCutoff |=> !torque_off_status ##0 ($past(safeTorqueCutoff) != torque_off_status))
    else $error("Torque-off status wrong");

  // No cutoff fault gives torque permitted one cycle on
  a_torque_on: assert property (@(posedge clk_sys) disable iff (!resetn)
    !safeTorqueCutoff |=> torque_off_status)
    else $error("Torque not shown as permitted");

  // A compare 0 write lands one cycle on
  a_compare0_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    compare0Write |=> travel_limit_compare_0 == $past(compareData))
    else $error("Compare 0 write lost");

  // A compare 1 write lands one cycle on
  a_compare_write: assert property (@(posedge clk_sys) disable iff (!resetn)
    compare1Write |=> travel_limit_compare_1 == $past(compareData))
    else $error("Compare 1 write lost");

  // Without a write compare 0 holds
  a_compare0_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !compare0Write |=> $stable(travel_limit_compare_0))
    else $error("Compare 0 changed without a write");

  // Without a write compare 1 holds
  a_compare1_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !compare1Write |=> $stable(travel_limit_compare_1))
    else $error("Compare 1 changed without a write");

endmodule

// ### sim/stlm_axis_model.sv
// Model of the axis position loop and homing logic at the monitor's far side.
// Assumes the monitor samples these outputs on the same clk_sys edge.
`timescale 1ns/1ps

module stlm_axis_model (
  input  wire logic                              clk_sys,
  input  wire logic                              resetn,
  input  wire logic signed [stlm_pkg::POS_W-1:0] targetPos,
  input  wire logic                              homeReq,
  output logic signed [stlm_pkg::POS_W-1:0]      actualPosition,
  output logic                                   axisHomed
);
  // Position follows the command one cycle late; a reset loses homing
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      actualPosition <= '0;
      axisHomed      <= 1'b0;
    end else begin
      actualPosition <= targetPos;
      axisHomed      <= homeReq;
    end
  end
endmodule

// ### sim/software_travel_limit_monitor_test.sv
// Self-checking bench of the travel limit monitor with an axis model.
// Assumes the monitor's fixed status latency of two cycles.
`timescale 1ns/1ps

module software_travel_limit_monitor_test;
  logic clk_sys = 1'b0, resetn = 1'b0, enableWrite = 1'b0, compare0Write = 1'b0;
  logic compare1Write = 1'b0, homeReq = 1'b0, hwLimitLower = 1'b0, hwLimitUpper = 1'b0;
  logic safeTorqueCutoff = 1'b0, axisHomed, torque_off_status, inhibitLower, inhibitUpper;
  logic [7:0] enableData = 8'h00, travel_limit_enable, travel_limit_status;
  logic signed [63:0] compareData = '0, targetPos = '0, actualPosition;
  logic signed [63:0] travel_limit_compare_0, travel_limit_compare_1;
  int error_cnt = 0, checks = 0, cycles = 0;

  stlm_monitor u_stlm_monitor (.clk_sys(clk_sys), .resetn(resetn),
    .enableWrite(enableWrite), .enableData(enableData), .compare0Write(compare0Write),
    .compare1Write(compare1Write), .compareData(compareData),
    .actualPosition(actualPosition), .axisHomed(axisHomed), .hwLimitLower(hwLimitLower),
    .hwLimitUpper(hwLimitUpper), .safeTorqueCutoff(safeTorqueCutoff),
    .travel_limit_enable(travel_limit_enable), .travel_limit_compare_0(travel_limit_compare_0),
    .travel_limit_compare_1(travel_limit_compare_1), .travel_limit_status(travel_limit_status),
    .torque_off_status(torque_off_status), .inhibitLower(inhibitLower),
    .inhibitUpper(inhibitUpper));
  stlm_axis_model u_stlm_axis_model (.clk_sys(clk_sys), .resetn(resetn), .targetPos(targetPos),
    .homeReq(homeReq), .actualPosition(actualPosition), .axisHomed(axisHomed));

  // 100 MHz clock and a hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      close_out();
    end
  end

  // Report and end the run
  task automatic close_out;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One setting write: strobe held for one edge
  task automatic wr(input int sel, input logic [63:0] data);
    @(posedge clk_sys);
    enableWrite   <= (sel == 0);
    compare0Write <= (sel == 1);
    compare1Write <= (sel == 2);
    enableData    <= data[7:0];
    compareData   <= data;
    @(posedge clk_sys);
    {enableWrite, compare0Write, compare1Write} <= 3'h0;
  endtask

  // Program limits, move the axis, then compare the settings, status and inhibits
  task automatic run(input logic [7:0] en, input logic signed [63:0] c0, c1, pos,
                     input logic homed, hl, hu);
    logic sw, lh, uh;
    wr(0, {56'h0, en});
    wr(1, c0);
    wr(2, c1);
    @(posedge clk_sys);
    targetPos    <= pos;
    homeReq      <= homed;
    hwLimitLower <= hl;
    hwLimitUpper <= hu;
    repeat (6) @(posedge clk_sys);
    #1;
    sw = (en[1:0] == 2'h3) && (c0 > c1);
    lh = homed && (pos < (sw ? c1 : c0)) && en[sw ? 1 : 0];
    uh = homed && (pos > (sw ? c0 : c1)) && en[sw ? 0 : 1];
    chk({56'h0, travel_limit_enable}, {62'h0, en[1:0]});
    chk(travel_limit_compare_0, c0);
    chk(travel_limit_compare_1, c1);
    chk({56'h0, travel_limit_status}, sw ? {62'h0, lh, uh} : {62'h0, uh, lh});
    chk({63'h0, inhibitLower}, {63'h0, hl | lh});
    chk({63'h0, inhibitUpper}, {63'h0, hu | uh});
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(travel_limit_compare_0, 64'h0);
    chk(travel_limit_compare_1, 64'h0000_0000_0010_0000);
    chk({56'h0, travel_limit_status}, 64'h0);
    chk({63'h0, torque_off_status}, 64'h1);
    run(8'h00, -64'sh32, 64'sh32, -64'sh384, 1'b1, 1'b0, 1'b0);
    run(8'h03, -64'sh32, 64'sh32, -64'sh384, 1'b0, 1'b0, 1'b0);
    run(8'h01, -64'sh32, 64'sh32, -64'sh33, 1'b1, 1'b0, 1'b0);
    run(8'h01, -64'sh32, 64'sh32, -64'sh32, 1'b1, 1'b0, 1'b0);
    run(8'h01, -64'sh32, 64'sh32, 64'sh384, 1'b1, 1'b0, 1'b0);
    run(8'h02, -64'sh32, 64'sh32, 64'sh33, 1'b1, 1'b0, 1'b0);
    run(8'h02, -64'sh32, 64'sh32, -64'sh384, 1'b1, 1'b1, 1'b0);
    run(8'h03, 64'sh32, -64'sh32, 64'sh33, 1'b1, 1'b0, 1'b1);
    run(8'h03, 64'sh32, -64'sh32, -64'sh33, 1'b1, 1'b0, 1'b0);
    run(8'h03, -64'sh32, 64'sh32, 64'sh384, 1'b1, 1'b0, 1'b0);
    run(8'h02, -64'sh32, 64'sh32, 64'sh32, 1'b1, 1'b0, 1'b0);
    run(8'h03, 64'sh32, 64'sh32, 64'sh32, 1'b1, 1'b0, 1'b0);
    run(8'hff, 64'sh8000_0000_0000_0000, 64'sh7fff_ffff_ffff_ffff, 64'sh0, 1'b1, 1'b0, 1'b0);
    @(posedge clk_sys);
    safeTorqueCutoff <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({63'h0, torque_off_status}, 64'h0);
    @(posedge clk_sys);
    safeTorqueCutoff <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({63'h0, torque_off_status}, 64'h1);
    close_out();
  end
endmodule
